// [bench/ppwm_ctrl_model.sv]
/* Printer video controller model: makes the dot clock and presents one
   pixel pair per dot period, one clock after each dot rise.
   Assumes the bench stages the next pair and may change the period. */
`default_nettype none
module ppwm_ctrl_model (
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   input  wire logic        run_in,
   input  wire logic [7:0]  period_in,
   input  wire logic [9:0]  pair_in,
   output var  logic        dot_clk_out,
   output var  logic [7:0]  pixel_code_out,
   output var  logic        sd_out,
   output var  logic        lt_out,
   output var  logic [15:0] rise_cnt_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ph_r;
   logic [7:0] ph_nxt;
   // Falling clock keeps the pins steady across the sampling edge
   always @(negedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ph_r           <= 8'h00;
         dot_clk_out    <= 1'b0;
         pixel_code_out <= 8'h00;
         sd_out         <= 1'b0;
         lt_out         <= 1'b0;
         rise_cnt_out   <= 16'h0000;
      end else if (!run_in) begin
         ph_r        <= period_in - 8'h01;
         dot_clk_out <= 1'b0;
      end else begin
         ph_nxt = (ph_r + 8'h01 >= period_in) ? 8'h00 : ph_r + 8'h01;
         ph_r        <= ph_nxt;
         dot_clk_out <= ph_nxt < (period_in >> 1);
         if (ph_nxt == 8'h00) begin
            rise_cnt_out <= rise_cnt_out + 16'h0001;
         end
         if (ph_nxt == 8'h01) begin
            {lt_out, sd_out, pixel_code_out} <= pair_in;
         end
      end
   end
endmodule
`default_nettype wire

// [bench/ppwm_top_chk.sv]
/* Checker of the pixel pulse width modulator top, bound to its ports.
   Assumes 72-clock dot periods except in a deliberate short-period test. */
`include "ppwm_defs.vh"
`default_nettype none
module ppwm_top_chk (
   input wire logic                     clk_in,
   input wire logic                     rstn_in,
   input wire logic                     ce_in,
   input wire logic                     dot_clk_in,
   input wire logic [`PPWM_CODE_W-1:0]  pixel_code_in,
   input wire logic                     single_dual_edge_select_in,
   input wire logic                     leading_trailing_select_in,
   input wire logic                     cal_req_in,
   input wire logic                     pwm_out,
   input wire logic                     cal_done_out,
   input wire logic                     cal_busy_out,
   input wire logic                     pixel_ready_out,
   input wire logic                     rate_fault_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] busy_age_r;
   logic [7:0] req_age_r;
   logic [1:0] dots_r;
   logic       dot_q_r;
   wire        quiet = dots_r == 2'h3 && !cal_busy_out && !cal_req_in && !rate_fault_out;
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         busy_age_r <= 8'h00;
         req_age_r  <= 8'h00;
         dots_r     <= 2'h0;
         dot_q_r    <= 1'b0;
      end else begin
         dot_q_r    <= dot_clk_in;
         busy_age_r <= !cal_busy_out ? 8'h00 : busy_age_r + {7'h00, busy_age_r != 8'hff};
         req_age_r  <= !cal_req_in ? 8'h00 : req_age_r + {7'h00, req_age_r != 8'hff};
         if (dot_clk_in && !dot_q_r && dots_r != 2'h3) begin
            dots_r <= dots_r + 2'h1;
         end
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   // First dot edges after reset only measure the period, hence the guard
   sequence s_take(logic [7:0] c);
      $rose(dot_clk_in) && pixel_code_in == c && quiet;
   endsequence
   sequence s_long_release;
      req_age_r == 8'hff ##1 !cal_req_in;
   endsequence
   a_full_high: assert property (s_take(8'hff) |-> ##7 pwm_out [*8])
      else $error("full code did not drive the output high");
   a_zero_low: assert property (s_take(8'h00) |-> ##7 !pwm_out [*8])
      else $error("zero code did not keep the output low");
   a_trail_start: assert property (s_take(8'h80) ##0 (single_dual_edge_select_in
      && !leading_trailing_select_in) |-> ##7 pwm_out)
      else $error("trailing placement did not rise at period start");
   a_lead_late: assert property (s_take(8'h80) ##0 (single_dual_edge_select_in
      && leading_trailing_select_in) |-> ##7 !pwm_out [*8])
      else $error("leading placement rose too early");
   a_center_late: assert property (s_take(8'h80) ##0
      !single_dual_edge_select_in |-> ##7 !pwm_out [*8])
      else $error("center placement rose too early");
   a_busy_on_req: assert property ($rose(cal_req_in) |-> ##[1:6] cal_busy_out)
      else $error("request did not raise busy");
   a_done_clear: assert property (cal_busy_out [*2] |-> !cal_done_out)
      else $error("done high while calibrating");
   a_busy_quiet: assert property (busy_age_r == 8'hff |-> !pwm_out)
      else $error("pulse emitted during calibration");
   a_cal_runs: assert property (s_long_release |-> ##1 cal_busy_out [*8])
      else $error("calibration did not start on request fall");
   a_rate_flag: assert property ($rose(dot_clk_in) ##4 $rose(dot_clk_in)
      |-> ##[1:8] rate_fault_out)
      else $error("short dot period not flagged");
endmodule
bind ppwm_top ppwm_top_chk u_chk (
   .clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .dot_clk_in(dot_clk_in),
   .pixel_code_in(pixel_code_in), .single_dual_edge_select_in(single_dual_edge_select_in),
   .leading_trailing_select_in(leading_trailing_select_in), .cal_req_in(cal_req_in),
   .pwm_out(pwm_out), .cal_done_out(cal_done_out), .cal_busy_out(cal_busy_out),
   .pixel_ready_out(pixel_ready_out), .rate_fault_out(rate_fault_out));
`default_nettype wire

// [bench/tb.sv]
/* Bench of the pixel pulse width modulator: calibration, placement table,
   full-scale codes, short dot period and a reset in mid-run.
   Assumes the controller model and the bound checker. */
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int P = 72;
   logic        clk_in = 1'b0;
   logic        rstn_in = 1'b0;
   logic        cal_req_in = 1'b0;
   logic        run = 1'b0;
   logic [7:0]  per = 8'h48;
   logic [9:0]  stage = 10'h000;
   wire         dot, sd, lt, pwm_out, cal_done_out, cal_busy_out;
   wire         pixel_ready_out, rate_fault_out;
   wire  [7:0]  code;
   wire  [15:0] rises;
   int          fails = 0;
   int          cmp_count = 0;
   int          age = 0;
   logic        pdot = 1'b0;
   logic        ppwm = 1'b0;
   int          r_start[$], r_len[$], r_per[$];
   int          kk[12];
   // Pairs as {lt, sd, code}; order avoids two pulses merging across a boundary
   logic [9:0]  tbl[12] = '{10'h180, 10'h380, 10'h080, 10'h280, 10'h140, 10'h1c0,
                            10'h104, 10'h100, 10'h2ff, 10'h100, 10'h3ff, 10'h000};
   always #2 clk_in = ~clk_in;
   ppwm_ctrl_model u_ctrl (.clk_in(clk_in), .rstn_in(rstn_in), .run_in(run),
      .period_in(per), .pair_in(stage), .dot_clk_out(dot), .pixel_code_out(code),
      .sd_out(sd), .lt_out(lt), .rise_cnt_out(rises));
   ppwm_top u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(1'b1), .dot_clk_in(dot),
      .pixel_code_in(code), .single_dual_edge_select_in(sd),
      .leading_trailing_select_in(lt), .cal_req_in(cal_req_in), .pwm_out(pwm_out),
      .cal_done_out(cal_done_out), .cal_busy_out(cal_busy_out),
      .pixel_ready_out(pixel_ready_out), .rate_fault_out(rate_fault_out));
   // Logs each high run: start clock after the dot rise, length, dot period
   always @(negedge clk_in) begin
      age = (dot && !pdot) ? 0 : age + 1;
      pdot = dot;
      if (pwm_out === 1'b1 && ppwm !== 1'b1) begin
         r_start.push_back(age);
         r_per.push_back(rises);
         r_len.push_back(0);
      end
      if (pwm_out === 1'b1 && r_len.size() > 0) r_len[$] = r_len[$] + 1;
      ppwm = pwm_out;
   end
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   function automatic logic near(input int a, input int b, input int t);
      return (a - b <= t) && (b - a <= t);
   endfunction
   // Stages a pair and returns once it stands on the pins, with its dot count
   task automatic put_pair(input logic [9:0] w, output int k);
      int n;
      stage <= w;
      k = rises;
      n = 0;
      while (rises == k && n < 400) begin
         @(negedge clk_in);
         n++;
      end
      if (n >= 400) begin
         fails++;
         final_report();
      end
      k = rises;
   endtask
   initial begin
      int n, k, base, j, off, es;
      repeat (8) @(negedge clk_in);
      rstn_in = 1'b1;
      check("cal_done_out", cal_done_out, 0);
      run <= 1'b1;
      put_pair(10'h3ff, k);
      cal_req_in = 1'b1;
      repeat (260) @(negedge clk_in);
      check("cal_busy_out", cal_busy_out, 1);
      cal_req_in = 1'b0;
      k = rises;
      base = r_len.size();
      n = 0;
      while (cal_done_out !== 1'b1 && n < 20000) begin
         @(negedge clk_in);
         n++;
      end
      if (n >= 20000) begin
         fails++;
         final_report();
      end
      check("cal dot edges", near(rises - k, ((P - 64) / 4 + 1) * 32, 2), 1);
      check("runs while calibrating", r_len.size(), base);
      put_pair(10'h100, k);
      put_pair(10'h100, k);
      base = r_len.size();
      for (int i = 0; i < 12; i++) put_pair(tbl[i], kk[i]);
      put_pair(10'h100, k);
      put_pair(10'h100, k);
      j = base;
      for (int i = 0; i < 12; i++) begin
         if (tbl[i][7:0] != 8'h00) begin
            off = (int'(tbl[i][7:0]) * P) >> 8;
            es = !tbl[i][8] ? 5 + P / 2 - off / 2 : (tbl[i][9] ? 5 + P - off : 5);
            if (tbl[i][7:0] == 8'hff) begin
               off = P;
               es = 5;
            end
            if (j < r_len.size()) begin
               check("run period", r_per[j], kk[i] + 1);
               check("run start", near(r_start[j], es, 1), 1);
               check("run width", near(r_len[j], off, 1), 1);
            end
            j++;
         end
      end
      check("run count", r_len.size(), j);
      check("pixel_ready_out", pixel_ready_out, 1);
      per <= 8'h04;
      repeat (60) @(negedge clk_in);
      check("rate_fault_out", rate_fault_out, 1);
      rstn_in = 1'b0;
      repeat (2) @(negedge clk_in);
      check("reset outputs", {pwm_out, cal_done_out, rate_fault_out, pixel_ready_out}, 4'h1);
      final_report();
   end
endmodule
`default_nettype wire

// [logic/ppwm_cal.v]
/*
 * Autocalibration sequencer: qualifies the request, then steps the ramp trim.
 * Assumes a filtered request level, a one-cycle dot tick and a ramp comparison.
 */
`include "ppwm_defs.vh"
`default_nettype none
module ppwm_cal (
   input  wire                    clk_in,
   input  wire                    rstn_in,
   input  wire                    ce_in,
   input  wire                    req_in,
   input  wire                    dot_tick_in,
   input  wire                    ramp_ok_in,
   output reg  [`PPWM_TRIM_W-1:0] trim_out,
   output reg                     done_out,
   output wire                    busy_out
);
   localparam ST_IDLE = 2'b00;
   localparam ST_HOLD = 2'b01;
   localparam ST_RUN  = 2'b10;
   localparam ST_DONE = 2'b11;

   reg [1:0]  state_r;
   reg [8:0]  hold_r;
   reg [4:0]  div_r;

   assign busy_out = (state_r == ST_HOLD) | (state_r == ST_RUN);

   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_r  <= ST_IDLE;
         hold_r   <= 9'h000;
         div_r    <= 5'h00;
         trim_out <= {`PPWM_TRIM_W{1'b0}};
         done_out <= 1'b0;
      end else if (ce_in) begin
         case (state_r)
            ST_IDLE, ST_DONE: begin
               if (req_in) begin
                  state_r  <= ST_HOLD;
                  hold_r   <= 9'h000;
                  done_out <= 1'b0;
               end
            end
            ST_HOLD: begin
               // Internal state reset while the request stands
               trim_out <= {`PPWM_TRIM_W{1'b0}};
               div_r    <= 5'h00;
               if (req_in) begin
                  if (hold_r != 9'h1ff) begin
                     hold_r <= hold_r + 1'b1;
                  end
               end else if (hold_r >= (`PPWM_CAL_REQ_CYC - 1)) begin
                  state_r <= ST_RUN;
               end else begin
                  // Too short a request is dropped, old trim discarded
                  state_r <= ST_IDLE;
               end
            end
            ST_RUN: begin
               if (req_in) begin
                  state_r <= ST_HOLD;
                  hold_r  <= 9'h000;
               end else if (dot_tick_in) begin
                  div_r <= div_r + 1'b1;
                  if (div_r == `PPWM_CAL_DIV) begin
                     if (ramp_ok_in || trim_out == `PPWM_CAL_STEPS) begin
                        state_r  <= ST_DONE;
                        done_out <= 1'b1;
                     end else begin
                        trim_out <= trim_out + 1'b1;
                     end
                  end
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// [logic/ppwm_defs.vh]
/*
 * Constants of the pixel pulse width modulator: widths, pin bit positions,
 * codes, calibration counts and timing figures.
 * Assumes the clock runs at 250 MHz and is included by its bare name.
 */
`ifndef PPWM_DEFS_VH
`define PPWM_DEFS_VH

`define PPWM_CODE_W        8
`define PPWM_LEN_W         12
`define PPWM_WORD_W        10
`define PPWM_PIN_W         12
`define PPWM_PIN_SD        8
`define PPWM_PIN_LT        9
`define PPWM_PIN_DOT       10
`define PPWM_PIN_CAL       11
`define PPWM_CODE_ZERO     8'h00
`define PPWM_CODE_FULL     8'hff
`define PPWM_FIFO_DEPTH    16
`define PPWM_FIFO_AW       4
`define PPWM_TRIM_W        7
`define PPWM_CAL_DIV       5'h1f
`define PPWM_CAL_STEPS     7'h40
`define PPWM_RAMP_BASE     12'h040
`define PPWM_TRIM_STEP     12'h004
`define PPWM_CLK_PERIOD_NS 4
`define PPWM_DOT_MIN_NS    20
`define PPWM_CAL_REQ_MIN_NS 1000
`define PPWM_DOT_MIN_CYC   ((`PPWM_DOT_MIN_NS + `PPWM_CLK_PERIOD_NS - 1) / `PPWM_CLK_PERIOD_NS)
`define PPWM_CAL_REQ_CYC   ((`PPWM_CAL_REQ_MIN_NS + `PPWM_CLK_PERIOD_NS - 1) / `PPWM_CLK_PERIOD_NS)

`endif

// [logic/ppwm_fifo.v]
/*
 * Pixel word FIFO, flip-flop storage addressed by index, valid/ready both sides.
 * Assumes one clock, a clock enable freezing all state and a synchronous flush.
 */
`include "ppwm_defs.vh"
`default_nettype none
module ppwm_fifo #(
   parameter W  = `PPWM_WORD_W,
   parameter D  = `PPWM_FIFO_DEPTH,
   parameter AW = `PPWM_FIFO_AW
) (
   input  wire          clk_in,
   input  wire          rstn_in,
   input  wire          ce_in,
   input  wire          flush_in,
   input  wire          in_valid_in,
   output wire          in_ready_out,
   input  wire [W-1:0]  in_data_in,
   output wire          out_valid_out,
   input  wire          out_ready_in,
   output wire [W-1:0]  out_data_out
);
   reg [W-1:0]  mem_r [0:D-1];
   reg [AW-1:0] wr_r;
   reg [AW-1:0] rd_r;
   reg [AW:0]   cnt_r;
   wire         push;
   wire         pop;

   assign in_ready_out  = (cnt_r != D[AW:0]);
   assign out_valid_out = (cnt_r != {(AW+1){1'b0}});
   assign out_data_out  = mem_r[rd_r];
   assign push          = in_valid_in & in_ready_out;
   assign pop           = out_valid_out & out_ready_in;

   always @(posedge clk_in) begin
      if (ce_in && push) begin
         mem_r[wr_r] <= in_data_in;
      end
   end

   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wr_r  <= {AW{1'b0}};
         rd_r  <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else if (ce_in) begin
         if (flush_in) begin
            wr_r  <= {AW{1'b0}};
            rd_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
         end else begin
            if (push) begin
               wr_r <= wr_r + 1'b1;
            end
            if (pop) begin
               rd_r <= rd_r + 1'b1;
            end
            if (push && !pop) begin
               cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
               cnt_r <= cnt_r - 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// [logic/ppwm_top.v]
/*
 * Pixel pulse width modulator top: pin synchronisers, dot period measurement,
 * pixel capture into a FIFO, fine time base pulse engine and calibration.
 * Assumes pins come from outside the clock domain and change only after the
 * dot clock rising edge, staying steady at least four clocks before the next.
 */
`include "ppwm_defs.vh"
`default_nettype none
module ppwm_top (
   input  wire                   clk_in,
   input  wire                   rstn_in,
   input  wire                   ce_in,
   input  wire                   dot_clk_in,
   input  wire [`PPWM_CODE_W-1:0] pixel_code_in,
   input  wire                   single_dual_edge_select_in,
   input  wire                   leading_trailing_select_in,
   input  wire                   cal_req_in,
   output reg                    pwm_out,
   output wire                   cal_done_out,
   output wire                   cal_busy_out,
   output wire                   pixel_ready_out,
   output reg                    rate_fault_out
);
   localparam MODE_LEADING  = 2'b00;
   localparam MODE_TRAILING = 2'b01;
   localparam MODE_CENTER   = 2'b10;

   // Fine offset: code times ramp length over 256
   function [`PPWM_LEN_W-1:0] ppwm_scale;
      input [`PPWM_CODE_W-1:0] code;
      input [`PPWM_LEN_W-1:0]  len;
      reg   [19:0]             prod;
      begin
         prod       = code * len;
         ppwm_scale = prod[19:8];
      end
   endfunction

   // Placement decode from the two select bits
   function [1:0] ppwm_mode;
      input sd;
      input lt;
      begin
         if (!sd) begin
            ppwm_mode = MODE_CENTER;
         end else if (lt) begin
            ppwm_mode = MODE_LEADING;
         end else begin
            ppwm_mode = MODE_TRAILING;
         end
      end
   endfunction

   wire [`PPWM_PIN_W-1:0] pins;
   reg  [`PPWM_PIN_W-1:0] s1_r;
   reg  [`PPWM_PIN_W-1:0] s2_r;
   reg  [`PPWM_PIN_W-1:0] s3_r;
   reg  [`PPWM_PIN_W-1:0] stable_r;
   reg  [`PPWM_PIN_W-1:0] stable_nxt;
   wire                   dot_rise;
   reg  [`PPWM_LEN_W-1:0] meas_r;
   reg  [`PPWM_LEN_W-1:0] period_r;
   reg                    period_valid_r;
   wire [`PPWM_TRIM_W-1:0] trim;
   wire                   cal_busy;
   wire                   cal_done;
   wire [`PPWM_LEN_W-1:0] ramp_len;
   wire                   ramp_ok;
   wire                   fifo_in_valid;
   wire                   fifo_in_ready;
   wire [`PPWM_WORD_W-1:0] fifo_in_data;
   wire                   fifo_out_valid;
   wire                   fifo_out_ready;
   wire [`PPWM_WORD_W-1:0] fifo_out_data;
   reg                    start_pend_r;
   reg                    active_r;
   reg  [`PPWM_CODE_W-1:0] code_r;
   reg  [1:0]             mode_r;
   reg  [`PPWM_LEN_W-1:0] phase_r;
   reg  [`PPWM_LEN_W-1:0] rise_r;
   reg  [`PPWM_LEN_W-1:0] fall_r;
   reg                    pwm_nxt;
   wire [`PPWM_LEN_W-1:0] offset;
   wire [`PPWM_LEN_W-1:0] half_len;
   wire [`PPWM_CODE_W-1:0] pop_code;
   wire [1:0]             pop_mode;
   wire                   engine_start;

   assign pins = {cal_req_in, dot_clk_in, leading_trailing_select_in,
                  single_dual_edge_select_in, pixel_code_in};

   // Three stages; the whole word moves only once stages two and three agree in every bit
   always @* begin
      stable_nxt = stable_r;
      if (s2_r == s3_r) begin
         stable_nxt = s3_r;
      end else begin
         stable_nxt = stable_r;
      end
   end

   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s1_r     <= {`PPWM_PIN_W{1'b0}};
         s2_r     <= {`PPWM_PIN_W{1'b0}};
         s3_r     <= {`PPWM_PIN_W{1'b0}};
         stable_r <= {`PPWM_PIN_W{1'b0}};
      end else if (ce_in) begin
         s1_r     <= pins;
         s2_r     <= s1_r;
         s3_r     <= s2_r;
         stable_r <= stable_nxt;
      end
   end

   assign dot_rise = stable_nxt[`PPWM_PIN_DOT] & ~stable_r[`PPWM_PIN_DOT];

   // Dot period in clocks, saturating; sets the ramp target
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         meas_r         <= {`PPWM_LEN_W{1'b0}};
         period_r       <= {`PPWM_LEN_W{1'b0}};
         period_valid_r <= 1'b0;
         rate_fault_out <= 1'b0;
      end else if (ce_in) begin
         if (dot_rise) begin
            meas_r         <= {{(`PPWM_LEN_W-1){1'b0}}, 1'b1};
            period_r       <= meas_r;
            period_valid_r <= 1'b1;
            // Below the minimum period the fine steps get too coarse
            rate_fault_out <= period_valid_r &&
                              (meas_r < `PPWM_DOT_MIN_CYC);
         end else if (meas_r != {`PPWM_LEN_W{1'b1}}) begin
            meas_r <= meas_r + 1'b1;
         end
      end
   end

   assign ramp_len = `PPWM_RAMP_BASE + {{(`PPWM_LEN_W-`PPWM_TRIM_W){1'b0}}, trim} *
                     `PPWM_TRIM_STEP;
   assign ramp_ok  = period_valid_r && (ramp_len >= period_r);

   ppwm_cal u_cal (
      .clk_in      (clk_in),
      .rstn_in     (rstn_in),
      .ce_in       (ce_in),
      .req_in      (stable_r[`PPWM_PIN_CAL]),
      .dot_tick_in (dot_rise),
      .ramp_ok_in  (ramp_ok),
      .trim_out    (trim),
      .done_out    (cal_done),
      .busy_out    (cal_busy)
   );

   assign cal_done_out = cal_done;
   assign cal_busy_out = cal_busy;

   // Old stable value at the edge is the pair presented at the previous edge
   assign fifo_in_valid = dot_rise & ~cal_busy;
   assign fifo_in_data  = stable_r[`PPWM_WORD_W-1:0];
   assign pixel_ready_out = fifo_in_ready;

   ppwm_fifo #(
      .W  (`PPWM_WORD_W),
      .D  (`PPWM_FIFO_DEPTH),
      .AW (`PPWM_FIFO_AW)
   ) u_fifo (
      .clk_in        (clk_in),
      .rstn_in       (rstn_in),
      .ce_in         (ce_in),
      .flush_in      (stable_r[`PPWM_PIN_CAL]),
      .in_valid_in   (fifo_in_valid),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (fifo_in_data),
      .out_valid_out (fifo_out_valid),
      .out_ready_in  (fifo_out_ready),
      .out_data_out  (fifo_out_data)
   );

   // Each word waits for the dot edge that opens its output period;
   // the engine stalls during calibration, and no words are captured then
   assign fifo_out_ready = start_pend_r & ~cal_busy;
   assign engine_start   = fifo_out_valid & fifo_out_ready;
   assign pop_code       = fifo_out_data[`PPWM_CODE_W-1:0];
   assign pop_mode       = ppwm_mode(fifo_out_data[`PPWM_PIN_SD],
                                     fifo_out_data[`PPWM_PIN_LT]);
   assign offset         = ppwm_scale(pop_code, ramp_len);
   assign half_len       = {1'b0, ramp_len[`PPWM_LEN_W-1:1]};

   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         start_pend_r <= 1'b0;
      end else if (ce_in) begin
         if (fifo_in_valid) begin
            start_pend_r <= 1'b1;
         end else if (engine_start || cal_busy) begin
            start_pend_r <= 1'b0;
         end
      end
   end

   // Edge positions fixed at the period start, in fine steps
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         active_r <= 1'b0;
         code_r   <= `PPWM_CODE_ZERO;
         mode_r   <= MODE_CENTER;
         phase_r  <= {`PPWM_LEN_W{1'b0}};
         rise_r   <= {`PPWM_LEN_W{1'b0}};
         fall_r   <= {`PPWM_LEN_W{1'b0}};
      end else if (ce_in) begin
         if (cal_busy) begin
            active_r <= 1'b0;
            code_r   <= `PPWM_CODE_ZERO;
         end else if (engine_start) begin
            active_r <= 1'b1;
            code_r   <= pop_code;
            mode_r   <= pop_mode;
            phase_r  <= {`PPWM_LEN_W{1'b0}};
            case (pop_mode)
               MODE_LEADING: begin
                  rise_r <= ramp_len - offset;
                  fall_r <= {`PPWM_LEN_W{1'b1}};
               end
               MODE_TRAILING: begin
                  rise_r <= {`PPWM_LEN_W{1'b0}};
                  fall_r <= offset;
               end
               MODE_CENTER: begin
                  rise_r <= half_len - {1'b0, offset[`PPWM_LEN_W-1:1]};
                  fall_r <= half_len + {1'b0, offset[`PPWM_LEN_W-1:1]};
               end
               default: begin
                  rise_r <= {`PPWM_LEN_W{1'b0}};
                  fall_r <= {`PPWM_LEN_W{1'b0}};
               end
            endcase
         end else if (active_r && phase_r != {`PPWM_LEN_W{1'b1}}) begin
            phase_r <= phase_r + 1'b1;
         end
      end
   end

   // Output level from the phase; leading placement holds high to period end
   always @* begin
      pwm_nxt = 1'b0;
      if (!active_r || cal_busy) begin
         pwm_nxt = 1'b0;
      end else if (code_r == `PPWM_CODE_ZERO) begin
         pwm_nxt = 1'b0;
      end else if (code_r == `PPWM_CODE_FULL) begin
         pwm_nxt = 1'b1;
      end else begin
         case (mode_r)
            MODE_LEADING: begin
               pwm_nxt = (phase_r >= rise_r);
            end
            MODE_TRAILING: begin
               pwm_nxt = (phase_r < fall_r);
            end
            MODE_CENTER: begin
               pwm_nxt = (phase_r >= rise_r) && (phase_r < fall_r);
            end
            default: begin
               pwm_nxt = 1'b0;
            end
         endcase
      end
   end

   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pwm_out <= 1'b0;
      end else if (ce_in) begin
         pwm_out <= pwm_nxt;
      end
   end
endmodule
`default_nettype wire
